// ### verilog/ppcr_regs.sv
// Per-port PHY control register bank: fault distance, forced mode, misc control.
// Assumes APB master on pclk; fault count arrives from same-clock diagnostic logic.
//
// The APB slave port was chosen for this implementation.
`default_nettype none
module ppcr_regs
    import ppcr_pkg::*;
#(
    parameter int NUM_PORTS = 4
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Diagnostic engine
    input wire logic fault_capture,
    input wire logic [8:0] fault_count,
    // Indicator requests from port logic
    input wire logic [NUM_PORTS*3-1:0] indicator_req_n,
    // Port controls
    output ppcr_mode_s mode_out,
    output ppcr_ctrl_s ctrl_out,
    output logic [NUM_PORTS*3-1:0] indicator_pin_n
);
    // ==========================================================
    // Bus decode
    // ==========================================================
    logic [ADDR_W-1:0] word_addr;
    logic access_ok;
    logic wr_en;
    logic rd_en;
    logic hit_fault_low;
    logic hit_fault_high;
    logic hit_mode;
    logic hit_misc;
    logic hit_any;
    assign word_addr = paddr[ADDR_W-1:0];
    assign access_ok = psel && penable;
    assign hit_fault_low = (word_addr == FAULT_LOW_ADDR);
    assign hit_fault_high = (word_addr == FAULT_HIGH_ADDR);
    assign hit_mode = (word_addr == FORCED_MODE_ADDR);
    assign hit_misc = (word_addr == MISC_CTRL_ADDR);
    // Upper address bits must be zero, so aliases of the bank answer with an error
    assign hit_any = (hit_fault_low || hit_fault_high || hit_mode || hit_misc) && (paddr[31:ADDR_W] == '0);
    assign wr_en = access_ok && pwrite && hit_any && pstrb[0];
    // Reads decode in the setup cycle, writes commit at the end of the access cycle
    assign rd_en = psel && !penable && !pwrite;
    // ==========================================================
    // Fault count storage
    // ==========================================================
    // Count width is fixed at nine bits by the distance encoding
    logic [8:0] fault_held;
    ppcr_fault_latch #(
        .COUNT_W(9)
    ) u_fault (
        .pclk(pclk),
        .presetn(presetn),
        .capture(fault_capture),
        .count_in(fault_count),
        .count_out(fault_held)
    );
    // ==========================================================
    // Control registers
    // ==========================================================
    logic [2:0] mode_reg;
    logic [2:0] mode_next;
    // Misc holds blank, transmitter disable and power down; reserved bits are not stored
    logic [2:0] misc_reg;
    logic [2:0] misc_next;
    logic restart_reg;
    logic restart_next;
    always_comb begin
        mode_next = mode_reg;
        misc_next = misc_reg;
        restart_next = 1'b0;
        if (wr_en && hit_mode) begin
            // negotiation disable and speed and duplex store
            mode_next = pwdata[NEG_DIS_BIT:DUPLEX_BIT];
        end
        if (wr_en && hit_misc) begin
            misc_next = {pwdata[BLANK_BIT], pwdata[TX_DIS_BIT], pwdata[PWR_DOWN_BIT]};
            restart_next = pwdata[RESTART_BIT];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= FORCED_MODE_RST[NEG_DIS_BIT:DUPLEX_BIT];
            misc_reg <= {MISC_CTRL_RST[BLANK_BIT], MISC_CTRL_RST[TX_DIS_BIT], MISC_CTRL_RST[PWR_DOWN_BIT]};
            restart_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            misc_reg <= misc_next;
            restart_reg <= restart_next;
        end
    end
    // ==========================================================
    // Read data
    // ==========================================================
    logic [31:0] rdata_next;
    logic [31:0] rdata_reg;
    // Loaded from the setup cycle so the word stands through the whole access cycle
    always_comb begin
        rdata_next = rdata_reg;
        if (rd_en) begin
            // Unmapped reads return zero alongside the error response
            rdata_next = 32'h0000_0000;
            if (hit_any && hit_fault_low) begin
                rdata_next[7:0] = fault_held[7:0];
            end
            if (hit_any && hit_fault_high) begin
                rdata_next[0] = fault_held[8];
            end
            if (hit_any && hit_mode) begin
                rdata_next[7:0] = {mode_reg, FORCED_RSVD_VAL};
            end
            if (hit_any && hit_misc) begin
                rdata_next[7:0] = {misc_reg[2], misc_reg[1], 1'b0, 1'b0, misc_reg[0], 3'h0};
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end
    // ==========================================================
    // Bus response
    // ==========================================================
    logic ready_next;
    logic slverr_next;
    always_comb begin
        // No wait states: the answer comes in the first access cycle
        ready_next = psel && !penable;
        // The error flag travels with ready so the master sees both at one edge
        slverr_next = psel && !penable && !hit_any;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= ready_next;
            pslverr <= slverr_next;
        end
    end
    // ==========================================================
    // Indicator pins
    // ==========================================================
    logic [NUM_PORTS*3-1:0] pin_next;
    logic [NUM_PORTS*3-1:0] pin_reg;
    // Blanking is registered with the requests, so the pins never glitch
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS*3; gi++) begin : g_ind
            assign pin_next[gi] = misc_reg[2] | indicator_req_n[gi];
        end
    endgenerate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_reg <= '1;
        end else begin
            pin_reg <= pin_next;
        end
    end
    // ==========================================================
    // Port control outputs
    // ==========================================================
    ppcr_mode_s mode_out_next;
    ppcr_mode_s mode_out_reg;
    ppcr_ctrl_s ctrl_out_next;
    ppcr_ctrl_s ctrl_out_reg;
    always_comb begin
        mode_out_next = ppcr_mode_s'(mode_reg);
        ctrl_out_next = '{tx_disable: misc_reg[1], restart_pulse: restart_reg, power_down: misc_reg[0]};
    end
    // Power down is passed to the port untouched; this bank does not sequence it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // speed shows 100 Mbit out of reset
            mode_out_reg <= ppcr_mode_s'(FORCED_MODE_RST[NEG_DIS_BIT:DUPLEX_BIT]);
            ctrl_out_reg <= '0;
        end else begin
            mode_out_reg <= mode_out_next;
            ctrl_out_reg <= ctrl_out_next;
        end
    end
    assign prdata = rdata_reg;
    assign indicator_pin_n = pin_reg;
    assign mode_out = mode_out_reg;
    assign ctrl_out = ctrl_out_reg;
endmodule : ppcr_regs
`default_nettype wire

// ### verilog/ppcr_pkg.sv
// Package for the per-port PHY control register bank.
// Assumes a 32-bit APB slave on pclk with one aligned word per register.
`default_nettype none
package ppcr_pkg;
    // ==========================================================
    // Register indices and byte addresses
    // ==========================================================
    localparam logic [7:0] FAULT_LOW_IDX = 8'h2b;
    localparam logic [7:0] FORCED_MODE_IDX = 8'h2c;
    localparam logic [7:0] MISC_CTRL_IDX = 8'h2d;
    localparam logic [7:0] FAULT_HIGH_IDX = 8'h2a;
    localparam logic [9:0] FAULT_LOW_ADDR = {FAULT_LOW_IDX, 2'b00};
    localparam logic [9:0] FORCED_MODE_ADDR = {FORCED_MODE_IDX, 2'b00};
    localparam logic [9:0] MISC_CTRL_ADDR = {MISC_CTRL_IDX, 2'b00};
    localparam logic [9:0] FAULT_HIGH_ADDR = {FAULT_HIGH_IDX, 2'b00};
    localparam int ADDR_W = 10;
    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int NEG_DIS_BIT = 7;
    localparam int SPEED_BIT = 6;
    localparam int DUPLEX_BIT = 5;
    localparam int BLANK_BIT = 7;
    localparam int TX_DIS_BIT = 6;
    localparam int RESTART_BIT = 5;
    localparam int PWR_DOWN_BIT = 3;
    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [7:0] FORCED_MODE_RST = 8'h5f;
    localparam logic [7:0] MISC_CTRL_RST = 8'h00;
    localparam logic [4:0] FORCED_RSVD_VAL = 5'h1f;
    // Fault distance step in decimetres per count
    localparam int FAULT_STEP_DM = 4;
    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic neg_disable;
        logic speed_100;
        logic full_duplex;
    } ppcr_mode_s;
    typedef struct packed {
        logic tx_disable;
        logic restart_pulse;
        logic power_down;
    } ppcr_ctrl_s;
endpackage : ppcr_pkg
`default_nettype wire

// ### verilog/ppcr_fault_latch.sv
// Holds the nine-bit cable fault count captured from the diagnostic engine.
// Assumes the capture strobe and count come from logic on pclk.
`default_nettype none
module ppcr_fault_latch #(
    parameter int COUNT_W = 9
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Capture side
    input wire logic capture,
    input wire logic [COUNT_W-1:0] count_in,
    // Held value
    output logic [COUNT_W-1:0] count_out
);
    logic [COUNT_W-1:0] count_reg;
    logic [COUNT_W-1:0] count_next;
    always_comb begin
        count_next = capture ? count_in : count_reg;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end
    assign count_out = count_reg;
endmodule : ppcr_fault_latch
`default_nettype wire

// ### verification/ppcr_regs_sva.sv
// Checker for the port PHY control register bank.
// Sees only the top module ports; bound from the bench top.
`default_nettype none
module ppcr_regs_sva
    import ppcr_pkg::*;
#(parameter int NUM_PORTS = 4) (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Port side
    input wire logic [NUM_PORTS*3-1:0] indicator_req_n,
    input wire ppcr_mode_s mode_out,
    input wire ppcr_ctrl_s ctrl_out,
    input wire logic [NUM_PORTS*3-1:0] indicator_pin_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Helpers and sequences
    // ==========================================================
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic mapped;
    assign acc = psel && penable && pready;
    assign mapped = paddr[9:0] inside {FAULT_LOW_ADDR, FAULT_HIGH_ADDR, FORCED_MODE_ADDR, MISC_CTRL_ADDR};
    sequence s_wr(a);
        acc && pwrite && pstrb[0] && paddr[9:0] == a;
    endsequence
    // ==========================================================
    // Properties
    // ==========================================================
    property p_ready; psel && !penable |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready");
    property p_unmap; acc && !mapped && !pwrite |-> pslverr && prdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped");
    property p_pins; &(indicator_pin_n | ~$past(indicator_req_n)); endproperty
    a_pins: assert property (p_pins) else $error("pin low");
    property p_blank; s_wr(MISC_CTRL_ADDR) ##0 pwdata[BLANK_BIT] |-> ##2 &indicator_pin_n; endproperty
    a_blank: assert property (p_blank) else $error("blank");
    property p_mode; s_wr(FORCED_MODE_ADDR) |-> ##2 mode_out == $past(pwdata[7:5], 2); endproperty
    a_mode: assert property (p_mode) else $error("mode");
    property p_tx; s_wr(MISC_CTRL_ADDR) |-> ##2 ctrl_out.tx_disable == $past(pwdata[6], 2); endproperty
    a_tx: assert property (p_tx) else $error("tx");
    property p_pulse; ctrl_out.restart_pulse |=> !ctrl_out.restart_pulse; endproperty
    a_pulse: assert property (p_pulse) else $error("pulse");
    property p_cause; s_wr(MISC_CTRL_ADDR) ##0 pwdata[RESTART_BIT] |-> ##[1:3] ctrl_out.restart_pulse; endproperty
    a_cause: assert property (p_cause) else $error("restart");
endmodule : ppcr_regs_sva
`default_nettype wire

// ### verification/ppcr_regs_tb_top.sv
// Bench top: random and corner APB traffic into the register bank.
// Drives every design input itself; no far-side model.
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module ppcr_regs_tb_top
    import ppcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fault_capture = 0;
    logic [31:0] paddr = 0, pwdata = 0, prdata, r, d, seed = 32'h61;
    logic [3:0] pstrb = 4'hf;
    logic [8:0] fault_count = 9'h000;
    logic [11:0] indicator_req_n = 12'hfff, indicator_pin_n;
    logic pready, pslverr, err;
    ppcr_mode_s mode_out;
    ppcr_ctrl_s ctrl_out;
    int errors = 0, total_checks = 0, pulses = 0, p0;
    ppcr_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fault_capture(fault_capture), .fault_count(fault_count), .indicator_req_n(indicator_req_n),
        .mode_out(mode_out), .ctrl_out(ctrl_out), .indicator_pin_n(indicator_pin_n));
    initial forever #5 pclk = ~pclk;
    always @(posedge pclk) if (ctrl_out.restart_pulse) pulses++;
    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Reserved low bits always read back set
    function automatic logic [31:0] exp_mode(input logic [31:0] v);
        return {24'h0, v[7:5], 5'h1f};
    endfunction : exp_mode
    function automatic logic [31:0] exp_misc(input logic [31:0] v);
        return {24'h0, v[7:6], 2'b00, v[3], 3'b000};
    endfunction : exp_misc
    task automatic conclude;
        if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {22'h0, a};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n < 16) begin
            r = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end else begin
            errors++;
            conclude();
        end
    endtask : apb
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK("mode_rst", 3'b010, mode_out)
        apb(0, FORCED_MODE_ADDR, 0);
        `CHK("fmode_rst", 32'h5f, r)
        apb(0, MISC_CTRL_ADDR, 0);
        `CHK("misc_rst", 32'h0, r)
        apb(0, FAULT_LOW_ADDR, 0);
        `CHK("flow_rst", 32'h0, r)
        // bench drives the indicator requests of all four ports from the seed
        // First eight passes walk every forced mode
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            d = (i < 8) ? {seed[31:8], i[2:0], seed[4:0]} : seed;
            apb(1, FORCED_MODE_ADDR, {d[31:5], FORCED_RSVD_VAL});
            apb(0, FORCED_MODE_ADDR, 0);
            `CHK("fmode", exp_mode(d), r)
            `CHK("mode", d[7:5], mode_out)
            indicator_req_n <= seed[11:0];
            p0 = pulses;
            apb(1, MISC_CTRL_ADDR, d);
            apb(0, MISC_CTRL_ADDR, 0);
            `CHK("misc", exp_misc(d), r)
            `CHK("pulse", 32'(d[5]), pulses - p0)
            `CHK("tx", d[6], ctrl_out.tx_disable)
            `CHK("pwr", d[3], ctrl_out.power_down)
            `CHK("pins", seed[11:0] | {12{d[7]}}, indicator_pin_n)
            fault_count <= seed[20:12];
            fault_capture <= 1'b1;
            @(posedge pclk);
            fault_capture <= 1'b0;
            apb(0, FAULT_LOW_ADDR, 0);
            `CHK("flow", {24'h0, seed[19:12]}, r)
            apb(0, FAULT_HIGH_ADDR, 0);
            `CHK("fhigh", seed[20], r[0])
            `CHK("err0", 1'b0, err)
        end
        // Byte lane 0 off: the write must be dropped
        pstrb <= 4'he;
        apb(1, FORCED_MODE_ADDR, {24'h0, ~d[7:5], FORCED_RSVD_VAL});
        pstrb <= 4'hf;
        apb(0, FORCED_MODE_ADDR, 0);
        `CHK("strb", exp_mode(d), r)
        apb(1, 10'h3fc, 32'hffff_ffff);
        `CHK("werr", 1'b1, err)
        apb(0, 10'h3fc, 0);
        `CHK("err", 1'b1, err)
        `CHK("rd0", 32'h0, r)
        conclude();
    end
endmodule : ppcr_regs_tb_top
bind ppcr_regs ppcr_regs_sva #(.NUM_PORTS(NUM_PORTS)) u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .indicator_req_n(indicator_req_n), .mode_out(mode_out),
    .ctrl_out(ctrl_out), .indicator_pin_n(indicator_pin_n));
`default_nettype wire
